// ==== logic/sdb_pkg.sv ====
/*
  Package for the SPI slave buffer block: register offsets, field
  positions, reset values, enumerations and timing counts.
  Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.
*/
package sdb_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 10;
  // Register byte offsets
  localparam logic [11:0] OFS_OWNER = 12'h400;
  localparam logic [11:0] OFS_CLAIM = 12'h404;
  localparam logic [11:0] OFS_STATUS = 12'h440;
  localparam logic [11:0] OFS_IRQ_EN = 12'h444;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h448;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_RX_PTR = 12'h534;
  localparam logic [11:0] OFS_RX_MAX = 12'h538;
  localparam logic [11:0] OFS_RX_AMT = 12'h53C;
  localparam logic [11:0] OFS_RX_LIST = 12'h540;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_MAX = 12'h548;
  localparam logic [11:0] OFS_TX_AMT = 12'h54C;
  localparam logic [11:0] OFS_TX_LIST = 12'h550;
  localparam logic [11:0] OFS_CONFIG = 12'h554;
  localparam logic [11:0] OFS_IGN_FILL = 12'h55C;
  localparam logic [11:0] OFS_OVR_FILL = 12'h5C0;
  // Field positions
  localparam int CFG_ORDER = 0;
  localparam int CFG_CPHA = 1;
  localparam int CFG_CPOL = 2;
  localparam int ST_TX_FLAG_A = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_END = 2;
  localparam logic [1:0] ENABLE_ON = 2'h2;
  localparam logic [31:0] BUS_RESET = 32'h0000_0000;
  localparam logic [1:0] CLAIM_TAKE = 2'h1;
  localparam logic [1:0] CLAIM_GIVE = 2'h2;
  // Buffer owner states
  typedef enum logic [1:0] {
    OWN_FREE = 2'b00,
    OWN_CPU = 2'b01,
    OWN_SLAVE = 2'b10,
    OWN_PENDING = 2'b11
  } sdb_owner_t;
  // Serial engine request answer latency in system clocks
  localparam int MEM_LAT = 1;
endpackage

// ==== logic/sdb_mem_if.sv ====
/*
  Interface joining the serial engine to the buffer access logic.
  Assumes one clock domain; requests are single-cycle pulses.
*/
`timescale 1ns/1ps
interface sdb_mem_if;
  logic rx_we;
  logic [7:0] rx_byte;
  logic [9:0] rx_idx;
  logic tx_re;
  logic [9:0] tx_idx;
  logic [7:0] tx_byte;
  modport eng (output rx_we, output rx_byte, output rx_idx, output tx_re, output tx_idx,
    input tx_byte);
  modport mem (input rx_we, input rx_byte, input rx_idx, input tx_re, input tx_idx,
    output tx_byte);
endinterface

// ==== logic/sdb_shift.sv ====
/*
  Serial shift engine of the SPI slave. Samples the synchronised link
  pins, shifts bytes per bit order, phase and polarity, fetches and
  stores buffer bytes through the memory interface.
  Assumes sck, csn and mosi are already double-synchronised.
*/
`timescale 1ns/1ps
module sdb_shift import sdb_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sck_s_i,
  input wire logic csn_s_i,
  input wire logic mosi_s_i,
  input wire logic granted_i,
  input wire logic lsb_first_i,
  input wire logic cpha_i,
  input wire logic cpol_i,
  input wire logic [9:0] rx_max_i,
  input wire logic [9:0] tx_max_i,
  input wire logic [7:0] ign_fill_i,
  input wire logic [7:0] ovr_fill_i,
  sdb_mem_if.eng mem,
  output logic miso_o,
  output logic frame_end_o,
  output logic [9:0] rx_cnt_o,
  output logic [9:0] tx_cnt_o,
  output logic tx_flag_a_o,
  output logic overflow_o
);
  logic sck_d_reg;
  logic csn_d_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_in_reg;
  logic [7:0] sh_out_reg;
  logic [9:0] rx_cnt_reg;
  logic [9:0] tx_cnt_reg;
  logic [10:0] byte_cnt_reg;
  logic gnt_reg;
  logic fetch_reg;
  logic lead, trail, sample_e, shift_e, start, load_e;
  logic [7:0] next_in;
  logic [7:0] load_byte;

  // Leading edge leaves the idle level set by polarity
  assign lead = (sck_s_i != sck_d_reg) && (sck_d_reg == cpol_i) && !csn_s_i;
  assign trail = (sck_s_i != sck_d_reg) && (sck_d_reg != cpol_i) && !csn_s_i;
  // Phase picks which edge samples and which shifts
  assign sample_e = cpha_i ? trail : lead;
  assign shift_e = cpha_i ? lead : trail;
  assign start = csn_d_reg && !csn_s_i;
  assign next_in = lsb_first_i ? {mosi_s_i, sh_in_reg[7:1]} : {sh_in_reg[6:0], mosi_s_i};
  // Fill byte choice for ignored or over-read bytes
  assign load_byte = !gnt_reg ? ign_fill_i :
                     (byte_cnt_reg[9:0] >= tx_max_i || byte_cnt_reg[10]) ? ovr_fill_i :
                     mem.tx_byte;
  assign miso_o = lsb_first_i ? sh_out_reg[0] : sh_out_reg[7];
  assign rx_cnt_o = rx_cnt_reg;
  assign tx_cnt_o = tx_cnt_reg;
  assign mem.rx_byte = next_in;
  assign mem.rx_idx = rx_cnt_reg;
  // Byte counter is cleared only at the start edge, so index zero is forced there
  assign mem.tx_idx = start ? 10'h000 : byte_cnt_reg[9:0] + 10'h001;

  // Edge history of the synchronised pins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sck_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s_i;
      csn_d_reg <= csn_s_i;
    end
  end

  // Fetch at frame start and at the last sample of each byte, so the next
  // byte is ready before its first shift edge and the pin is not late
  assign mem.tx_re = start || (sample_e && bit_reg == 3'h7);
  // Phase 0 loads right after start, otherwise on the first shift edge of a byte
  assign load_e = (fetch_reg && !cpha_i) || (shift_e && bit_reg == 3'h0);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= start;
    end
  end

  // Bit and byte sequencing over one frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bit_reg <= 3'h0;
      sh_in_reg <= 8'h00;
      sh_out_reg <= 8'h00;
      rx_cnt_reg <= 10'h000;
      tx_cnt_reg <= 10'h000;
      byte_cnt_reg <= 11'h000;
      gnt_reg <= 1'b0;
      tx_flag_a_o <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      tx_flag_a_o <= 1'b0;
      overflow_o <= 1'b0;
      if (start) begin
        gnt_reg <= granted_i;
        bit_reg <= 3'h0;
        byte_cnt_reg <= 11'h000;
        rx_cnt_reg <= 10'h000;
        tx_cnt_reg <= 10'h000;
      end else if (load_e) begin
        sh_out_reg <= load_byte;
        if (gnt_reg && byte_cnt_reg[9:0] < tx_max_i && !byte_cnt_reg[10]) begin
          tx_cnt_reg <= tx_cnt_reg + 10'h001;
        end else if (gnt_reg) begin
          tx_flag_a_o <= 1'b1;
        end
      end else if (shift_e) begin
        sh_out_reg <= lsb_first_i ? {1'b0, sh_out_reg[7:1]} : {sh_out_reg[6:0], 1'b0};
      end
      if (sample_e) begin
        sh_in_reg <= next_in;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          if (!byte_cnt_reg[10]) begin
            byte_cnt_reg <= byte_cnt_reg + 11'h001;
          end
          if (gnt_reg && rx_cnt_reg < rx_max_i) begin
            rx_cnt_reg <= rx_cnt_reg + 10'h001;
          end else if (gnt_reg) begin
            overflow_o <= 1'b1;
          end
        end
      end
    end
  end
  assign mem.rx_we = sample_e && bit_reg == 3'h7 && gnt_reg && rx_cnt_reg < rx_max_i;
  assign frame_end_o = !csn_d_reg && csn_s_i;

  a_rx_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mem.rx_we |-> rx_cnt_reg < rx_max_i) else $error("rx write beyond max");
  a_tx_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_cnt_reg <= tx_max_i || !gnt_reg) else $error("tx count beyond max");
endmodule

// ==== logic/sdb_top.sv ====
/*
  SPI slave buffer block top: Avalon-MM register file, buffer owner
  semaphore, link pin synchronisers, on-chip rx/tx buffers, interrupt.
  Assumes an external SPI master drives sck, csn and mosi; the block
  clock runs at 40 MHz and oversamples the link clock.
*/
`timescale 1ns/1ps
module sdb_top import sdb_pkg::*; #(
  parameter int DEPTH = 1024
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  output logic irq_o
);
  sdb_mem_if mif ();
  sdb_owner_t owner_reg;
  logic [1:0] enable_reg;
  logic [2:0] config_reg;
  logic [9:0] rx_max_reg, tx_max_reg, rx_amt_reg, tx_amt_reg;
  logic [31:0] rx_ptr_reg, tx_ptr_reg;
  logic rx_list_reg, tx_list_reg;
  logic [7:0] ign_fill_reg, ovr_fill_reg;
  logic [2:0] status_reg, irq_en_reg;
  logic [2:0] sck_m_reg, csn_m_reg, mosi_m_reg;
  logic [1:0] sck_sy_reg, csn_sy_reg, mosi_sy_reg;
  logic ack_reg;
  logic [31:0] rdata_next;
  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [7:0] tx_byte_reg;
  logic frame_end, ovr_ev, ofl_ev, gnt, csn_eff, wr;
  logic [9:0] rx_cnt, tx_cnt;

  // Two-flop synchronisers; first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sck_sy_reg <= 2'b00;
      csn_sy_reg <= 2'b11;
      mosi_sy_reg <= 2'b00;
    end else begin
      sck_sy_reg <= {sck_sy_reg[0], sck_i};
      csn_sy_reg <= {csn_sy_reg[0], csn_i};
      mosi_sy_reg <= {mosi_sy_reg[0], mosi_i};
    end
  end

  // Disabled slave sees the bus as deselected
  assign csn_eff = csn_sy_reg[1] || (enable_reg != ENABLE_ON);
  assign gnt = (owner_reg == OWN_SLAVE) || (owner_reg == OWN_PENDING);
  assign miso_oe_n_o = csn_eff;

  sdb_shift u_shift (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sck_s_i(sck_sy_reg[1]),
    .csn_s_i(csn_eff),
    .mosi_s_i(mosi_sy_reg[1]),
    .granted_i(gnt),
    .lsb_first_i(config_reg[CFG_ORDER]),
    .cpha_i(config_reg[CFG_CPHA]),
    .cpol_i(config_reg[CFG_CPOL]),
    .rx_max_i(rx_max_reg),
    .tx_max_i(tx_max_reg),
    .ign_fill_i(ign_fill_reg),
    .ovr_fill_i(ovr_fill_reg),
    .mem(mif.eng),
    .miso_o(miso_o),
    .frame_end_o(frame_end),
    .rx_cnt_o(rx_cnt),
    .tx_cnt_o(tx_cnt),
    .tx_flag_a_o(ovr_ev),
    .overflow_o(ofl_ev)
  );

  // Buffer storage, indexed from the start of each frame
  always_ff @(posedge clk_i) begin
    if (mif.rx_we) begin
      rx_mem[mif.rx_idx] <= mif.rx_byte;
    end
    if (mif.tx_re) begin
      tx_byte_reg <= tx_mem[mif.tx_idx];
    end
    if (wr && avs_address_i[11:10] == 2'b11 && avs_byteenable_i[0]) begin
      tx_mem[avs_address_i[9:0]] <= avs_writedata_i[7:0];
    end
  end
  assign mif.tx_byte = tx_byte_reg;

  // One wait state on every access: answer at the second edge
  assign wr = avs_write_i && ack_reg;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end
  end

  // Software registers, each written at its own offset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable_reg <= 2'h0;
      config_reg <= 3'h0;
      rx_max_reg <= 10'h000;
      tx_max_reg <= 10'h000;
      rx_ptr_reg <= BUS_RESET;
      tx_ptr_reg <= BUS_RESET;
      rx_list_reg <= 1'b0;
      tx_list_reg <= 1'b0;
      ign_fill_reg <= 8'h00;
      ovr_fill_reg <= 8'h00;
      irq_en_reg <= 3'h0;
    end else if (wr) begin
      if (avs_address_i == OFS_ENABLE) begin
        enable_reg <= avs_writedata_i[1:0];
      end else if (avs_address_i == OFS_CONFIG) begin
        config_reg <= avs_writedata_i[2:0];
      end else if (avs_address_i == OFS_RX_MAX) begin
        rx_max_reg <= avs_writedata_i[9:0];
      end else if (avs_address_i == OFS_TX_MAX) begin
        tx_max_reg <= avs_writedata_i[9:0];
      end else if (avs_address_i == OFS_RX_PTR) begin
        rx_ptr_reg <= avs_writedata_i;
      end else if (avs_address_i == OFS_TX_PTR) begin
        tx_ptr_reg <= avs_writedata_i;
      end else if (avs_address_i == OFS_RX_LIST) begin
        rx_list_reg <= avs_writedata_i[0];
      end else if (avs_address_i == OFS_TX_LIST) begin
        tx_list_reg <= avs_writedata_i[0];
      end else if (avs_address_i == OFS_IGN_FILL) begin
        ign_fill_reg <= avs_writedata_i[7:0];
      end else if (avs_address_i == OFS_OVR_FILL) begin
        ovr_fill_reg <= avs_writedata_i[7:0];
      end else if (avs_address_i == OFS_IRQ_EN) begin
        irq_en_reg <= avs_writedata_i[2:0];
      end
    end
  end

  // Amounts latched when chip select rises on a granted frame
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_amt_reg <= 10'h000;
      tx_amt_reg <= 10'h000;
    end else if (frame_end && gnt) begin
      rx_amt_reg <= rx_cnt;
      tx_amt_reg <= tx_cnt;
    end
  end

  // Sticky flags: hardware set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= (status_reg & ~((wr && (avs_address_i == OFS_STATUS ||
        avs_address_i == OFS_IRQ_CLR)) ? avs_writedata_i[2:0] : 3'h0)) |
        {frame_end && gnt, ofl_ev, ovr_ev};
    end
  end
  assign irq_o = |(status_reg & irq_en_reg);

  // Owner semaphore: claim, release and handover at frame end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      owner_reg <= OWN_CPU; // Buffers start out held by the processor
    end else begin
      case (owner_reg)
        OWN_FREE: begin
          if (wr && avs_address_i == OFS_CLAIM && avs_writedata_i[1:0] == CLAIM_TAKE) begin
            owner_reg <= OWN_CPU;
          end
        end
        OWN_CPU: begin
          if (wr && avs_address_i == OFS_CLAIM && avs_writedata_i[1:0] == CLAIM_GIVE) begin
            owner_reg <= OWN_SLAVE;
          end
        end
        OWN_SLAVE: begin
          if (wr && avs_address_i == OFS_CLAIM && avs_writedata_i[1:0] == CLAIM_TAKE) begin
            owner_reg <= OWN_PENDING;
          end
        end
        OWN_PENDING: begin
          if (frame_end) begin
            owner_reg <= OWN_CPU;
          end
        end
        default: begin
          owner_reg <= OWN_FREE;
        end
      endcase
    end
  end

  // Read decode; unmapped reads return zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (avs_address_i == OFS_OWNER) begin
      rdata_next = {30'h0, owner_reg};
    end else if (avs_address_i == OFS_STATUS) begin
      rdata_next = {29'h0, status_reg};
    end else if (avs_address_i == OFS_IRQ_EN) begin
      rdata_next = {29'h0, irq_en_reg};
    end else if (avs_address_i == OFS_ENABLE) begin
      rdata_next = {30'h0, enable_reg};
    end else if (avs_address_i == OFS_RX_PTR) begin
      rdata_next = rx_ptr_reg;
    end else if (avs_address_i == OFS_RX_MAX) begin
      rdata_next = {22'h0, rx_max_reg};
    end else if (avs_address_i == OFS_RX_AMT) begin
      rdata_next = {22'h0, rx_amt_reg};
    end else if (avs_address_i == OFS_RX_LIST) begin
      rdata_next = {31'h0, rx_list_reg};
    end else if (avs_address_i == OFS_TX_PTR) begin
      rdata_next = tx_ptr_reg;
    end else if (avs_address_i == OFS_TX_MAX) begin
      rdata_next = {22'h0, tx_max_reg};
    end else if (avs_address_i == OFS_TX_AMT) begin
      rdata_next = {22'h0, tx_amt_reg};
    end else if (avs_address_i == OFS_TX_LIST) begin
      rdata_next = {31'h0, tx_list_reg};
    end else if (avs_address_i == OFS_CONFIG) begin
      rdata_next = {29'h0, config_reg};
    end else if (avs_address_i == OFS_IGN_FILL) begin
      rdata_next = {24'h0, ign_fill_reg};
    end else if (avs_address_i == OFS_OVR_FILL) begin
      rdata_next = {24'h0, ovr_fill_reg};
    end else if (avs_address_i[11:10] == 2'b10) begin
      rdata_next = {24'h0, rx_mem[avs_address_i[9:0]]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
      avs_readdata_o <= rdata_next;
    end
  end

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovr_ev |=> status_reg[ST_TX_FLAG_A]) else $error("over-read flag lost");
  a_disabled_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    enable_reg != ENABLE_ON |-> miso_oe_n_o && !mif.rx_we && !mif.tx_re)
    else $error("active while disabled");
  a_moved_byte_count_frame: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    frame_end && gnt |=> rx_amt_reg == $past(rx_cnt)) else $error("moved_byte_count not latched");
  a_handover_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    owner_reg == OWN_PENDING && frame_end |=> owner_reg == OWN_CPU)
    else $error("handover missed");
  a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o == |(status_reg & irq_en_reg)) else $error("irq mismatch");
  a_bus_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("wait state wrong");
endmodule

// ==== dv/sdb_spi_master.sv ====
/*
  Behavioural SPI master that drives the slave's link pins.
  Assumes the block clock paces it: half a link period is four clocks.
*/
`timescale 1ns/1ps
module sdb_spi_master (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic sck_o,
  output logic csn_o,
  output logic mosi_o
);
  logic [7:0] tx_b [4];
  logic [7:0] rx_b [4];
  logic oe_low;

  // Idle pins
  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    mosi_o = 1'b0;
    oe_low = 1'b0;
  end

  // Sample the data line; a released line reads as pulled high
  task automatic take(input logic [2:0] cfg, input int i, input int j);
    logic m;
    m = (miso_oe_n_i === 1'b0) ? miso_i : 1'b1;
    if (miso_oe_n_i === 1'b0) oe_low = 1'b1;
    rx_b[i][cfg[0] ? j : 7 - j] = m;
  endtask

  // One frame of n bytes; cfg holds order, phase and polarity
  task automatic frame(input logic [2:0] cfg, input int n);
    int i;
    int j;
    oe_low = 1'b0;
    @(posedge clk_i);
    sck_o <= cfg[2];
    repeat (4) @(posedge clk_i);
    csn_o <= 1'b0;
    repeat (40) @(posedge clk_i);
    for (i = 0; i < n; i++) begin
      for (j = 0; j < 8; j++) begin
        if (!cfg[1]) mosi_o <= tx_b[i][cfg[0] ? j : 7 - j];
        repeat (4) @(posedge clk_i);
        if (!cfg[1]) take(cfg, i, j);
        sck_o <= ~cfg[2];
        if (cfg[1]) mosi_o <= tx_b[i][cfg[0] ? j : 7 - j];
        repeat (4) @(posedge clk_i);
        if (cfg[1]) take(cfg, i, j);
        sck_o <= cfg[2];
      end
    end
    // Clock to select hold, then release select and invert the data line
    repeat (80) @(posedge clk_i);
    csn_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (16) @(posedge clk_i);
  endtask
endmodule

// ==== dv/tb_top.sv ====
/*
  Self-checking bench for the SPI slave buffer block: register tasks,
  buffer handover and framed transfers in every link mode.
  Assumes the behavioural master model and a 40 MHz block clock.
*/
`timescale 1ns/1ps
module tb_top import sdb_pkg::*; ;
  logic clk_i;
  logic sys_rst_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sck_i;
  logic csn_i;
  logic mosi_i;
  logic miso_o;
  logic miso_oe_n_o;
  logic irq_o;
  int num_errors;
  int check_count;
  int c;
  logic [2:0] cf;
  localparam logic [11:0] RST_OFS [8] = '{OFS_RX_MAX, OFS_TX_PTR, OFS_TX_MAX, OFS_TX_AMT,
    OFS_TX_LIST, OFS_CONFIG, OFS_IGN_FILL, OFS_OVR_FILL};
  localparam logic [7:0] ORC_V = 8'hA7;
  localparam logic [7:0] DEF_V = 8'h4D;

  sdb_top #(.DEPTH(1024)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sck_i(sck_i), .csn_i(csn_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .irq_o(irq_o));

  sdb_spi_master m (.clk_i(clk_i), .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o),
    .sck_o(sck_i), .csn_o(csn_i), .mosi_o(mosi_i));

  // Block clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Avalon access: hold the request until waitrequest is sampled low;
  // a slave that never answers is caught by the watchdog
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check($sformatf("reg %h", a), q, exp);
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake or frame
  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    sys_rst_i = 1'b1;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, refused writes, write readback
    for (int i = 0; i < 8; i++) rd_chk(RST_OFS[i], BUS_RESET);
    rd_chk(OFS_OWNER, {30'h0, OWN_CPU});
    rd_chk(OFS_STATUS, 32'h0);
    wr(12'h010, 32'h1234_5678);
    rd_chk(12'h010, 32'h0);
    wr(OFS_TX_AMT, 32'h5);
    rd_chk(OFS_TX_AMT, 32'h0);
    wr(OFS_TX_PTR, 32'h2000_1234);
    rd_chk(OFS_TX_PTR, 32'h2000_1234);
    wr(OFS_RX_MAX, 32'h3FF);
    rd_chk(OFS_RX_MAX, 32'h3FF);
    wr(OFS_RX_MAX, 32'h2);
    wr(OFS_TX_MAX, 32'h2);
    wr(OFS_OVR_FILL, {24'h0, ORC_V});
    wr(OFS_IGN_FILL, {24'h0, DEF_V});
    wr(OFS_ENABLE, {30'h0, ENABLE_ON});
    wr(OFS_CLAIM, {30'h0, CLAIM_TAKE});
    rd_chk(OFS_OWNER, {30'h0, OWN_CPU});
    // Granted frames of three bytes in all eight link modes
    for (c = 0; c < 8; c++) begin
      cf = c[2:0];
      wr(OFS_CONFIG, {29'h0, cf});
      wr(OFS_IRQ_EN, (c == 0) ? 32'h0 : 32'h7);
      wr(12'hC00, {24'h0, 8'h1E + 8'(c)});
      wr(12'hC01, {24'h0, 8'hC4 + 8'(c)});
      wr(OFS_CLAIM, {30'h0, CLAIM_GIVE});
      rd_chk(OFS_OWNER, {30'h0, OWN_SLAVE});
      wr(OFS_CLAIM, {30'h0, CLAIM_TAKE});
      rd_chk(OFS_OWNER, {30'h0, OWN_PENDING});
      m.tx_b[0] = 8'h35 + 8'(c);
      m.tx_b[1] = 8'h6B + 8'(c);
      m.tx_b[2] = 8'hF0;
      m.frame(cf, 3);
      check("miso byte 0", {24'h0, m.rx_b[0]}, {24'h0, 8'h1E + 8'(c)});
      check("miso byte 1", {24'h0, m.rx_b[1]}, {24'h0, 8'hC4 + 8'(c)});
      check("miso byte 2", {24'h0, m.rx_b[2]}, {24'h0, ORC_V});
      rd_chk(OFS_RX_AMT, 32'h2);
      rd_chk(OFS_TX_AMT, 32'h2);
      rd_chk(12'h800, {24'h0, 8'h35 + 8'(c)});
      rd_chk(12'h801, {24'h0, 8'h6B + 8'(c)});
      rd_chk(OFS_STATUS, 32'h7);
      rd_chk(OFS_OWNER, {30'h0, OWN_CPU});
      check("irq", {31'h0, irq_o}, {31'h0, c != 0});
      wr(c[0] ? OFS_STATUS : OFS_IRQ_CLR, 32'h7);
      rd_chk(OFS_STATUS, 32'h0);
      check("irq", {31'h0, irq_o}, 32'h0);
    end
    // Buffers held by the processor: the frame is ignored
    wr(OFS_CONFIG, 32'h0);
    m.frame(3'h0, 2);
    check("ignored byte 0", {24'h0, m.rx_b[0]}, {24'h0, DEF_V});
    check("ignored byte 1", {24'h0, m.rx_b[1]}, {24'h0, DEF_V});
    rd_chk(OFS_TX_AMT, 32'h2);
    rd_chk(OFS_STATUS, 32'h0);
    check("irq ignored", {31'h0, irq_o}, 32'h0);
    check("line driven", {31'h0, m.oe_low}, 32'h1);
    // Disabled slave leaves its data line released
    wr(OFS_ENABLE, 32'h0);
    m.frame(3'h0, 1);
    check("line driven", {31'h0, m.oe_low}, 32'h0);
    check("released byte", {24'h0, m.rx_b[0]}, 32'hFF);
    report_and_stop();
  end
endmodule
